// ==== plc_device_access_command_decoder.sv ====
`timescale 1ns/1ps
module plc_device_access_command_decoder (
	input  wire logic                                 clk,
	input  wire logic                                 resetn,
	input  wire logic                                 reqValid,
	output logic                                      reqReady,
	input  wire logic [7:0]                           reqCode,
	input  wire logic [7:0]                           reqStation,
	input  wire logic [8:0]                           reqCount,
	input  wire logic                                 reqWordBits,
	input  wire logic                                 entryValid,
	output logic                                      entryReady,
	input  wire logic [plc_access_pkg::ENTRY_W-1:0]   entryAddr,
	input  wire logic                                 runWritePermitSwitch,
	input  wire logic                                 cpuRunning,
	output logic                                      cpuReq,
	output logic [7:0]                                cpuCode,
	output logic [7:0]                                cpuStation,
	output logic [8:0]                                cpuCount,
	output logic                                      cpuEntryValid,
	output logic [plc_access_pkg::ENTRY_W-1:0]        cpuEntryAddr,
	input  wire logic                                 cpuDone,
	input  wire logic                                 cpuError,
	output logic                                      respValid,
	output logic [2:0]                                respStatus
);
	import plc_access_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_LOAD, S_REPLAY, S_CPU, S_RESP} state_t;

	state_t      state_reg, state_next;
	logic [7:0]  code_reg, code_next;
	logic [7:0]  station_reg, station_next;
	logic [8:0]  count_reg, count_next;
	logic        bank_reg, bank_next;
	logic [5:0]  idx_reg, idx_next;
	logic        rdPend_reg, rdPend_next;
	logic [5:0]  devCnt_reg, devCnt_next;
	logic        devWord_reg, devWord_next;
	logic [5:0]  extCnt_reg, extCnt_next;
	logic        cpuReq_reg, cpuReq_next;
	logic        entryReady_reg, entryReady_next;
	logic        respValid_reg, respValid_next;
	logic        reqReady_reg, reqReady_next;
	logic [2:0]  respStatus_reg, respStatus_next;
	logic        permitMeta_reg, permit_reg;

	logic            known;
	logic            isWrite;
	logic [8:0]      limit;
	cmd_kind_t       kind;
	logic            bank;
	logic            accept;
	logic            memWrEn;
	logic [MON_AW-1:0] memRdAddr;
	logic [5:0]      bankCnt;
	logic            regOk;

	cmd_limit_table u_table (
		.code     (reqCode),
		.wordBits (reqWordBits),
		.known    (known),
		.isWrite  (isWrite),
		.limit    (limit),
		.kind     (kind),
		.bank     (bank)
	);

	monitor_store u_store (
		.clk    (clk),
		.wrEn   (memWrEn),
		.wrAddr ({bank_reg, idx_reg}),
		.wrData (entryAddr),
		.rdAddr (memRdAddr),
		.rdData (cpuEntryAddr)
	);

	// Switch pin synchroniser
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			permitMeta_reg <= 1'b0;
			permit_reg     <= 1'b0;
		end else begin
			permitMeta_reg <= runWritePermitSwitch;
			permit_reg     <= permitMeta_reg;
		end
	end

	assign accept    = reqValid && reqReady_reg;
	assign memWrEn   = (state_reg == S_LOAD) && entryValid && entryReady_reg;
	assign memRdAddr = {bank_reg, idx_reg};
	assign bankCnt   = (bank == BANK_EXT) ? extCnt_reg : devCnt_reg;
	assign regOk     = (bankCnt != IDX_RESET) &&
	                   ((bank == BANK_EXT) || (devWord_reg == (reqCode == CMD_WORD_MON)));

	always_comb begin
		state_next      = state_reg;
		code_next       = code_reg;
		station_next    = station_reg;
		count_next      = count_reg;
		bank_next       = bank_reg;
		idx_next        = idx_reg;
		rdPend_next     = 1'b0;
		devCnt_next     = devCnt_reg;
		devWord_next    = devWord_reg;
		extCnt_next     = extCnt_reg;
		cpuReq_next     = cpuReq_reg;
		entryReady_next = entryReady_reg;
		respValid_next  = 1'b0;
		respStatus_next = respStatus_reg;
		case (state_reg)
			S_IDLE: begin
				if (accept) begin
					code_next    = reqCode;
					station_next = reqStation;
					count_next   = reqCount;
					bank_next    = bank;
					idx_next     = IDX_RESET;
					if (!known) begin
						respStatus_next = ST_BAD_CODE;
						respValid_next  = 1'b1;
						state_next      = S_RESP;
					end else if (kind != KIND_MONITOR &&
					             (reqCount > limit || reqCount == LIM_0)) begin
						respStatus_next = ST_BAD_COUNT;
						respValid_next  = 1'b1;
						state_next      = S_RESP;
					end else if (isWrite && cpuRunning && !permit_reg) begin
						respStatus_next = ST_WRITE_OFF;
						respValid_next  = 1'b1;
						state_next      = S_RESP;
					end else if (kind == KIND_MONITOR && !regOk) begin
						respStatus_next = ST_NOT_REG;
						respValid_next  = 1'b1;
						state_next      = S_RESP;
					end else if (kind == KIND_REGISTER) begin
						if (bank == BANK_EXT) begin
							extCnt_next = IDX_RESET;
						end else begin
							devCnt_next  = IDX_RESET;
							devWord_next = (reqCode == CMD_WORD_MON_REG);
						end
						entryReady_next = 1'b1;
						state_next      = S_LOAD;
					end else if (kind == KIND_MONITOR) begin
						count_next = {3'h0, bankCnt};
						state_next = S_REPLAY;
					end else begin
						cpuReq_next = 1'b1;
						state_next  = S_CPU;
					end
				end
			end
			S_LOAD: begin
				if (memWrEn) begin
					idx_next = idx_reg + 6'h01;
					if ({3'h0, idx_reg} == count_reg - 9'h001) begin
						if (bank_reg == BANK_EXT) begin
							extCnt_next = idx_reg + 6'h01;
						end else begin
							devCnt_next = idx_reg + 6'h01;
						end
						entryReady_next = 1'b0;
						cpuReq_next     = 1'b1;
						state_next      = S_CPU;
					end
				end
			end
			S_REPLAY: begin
				if ({3'h0, idx_reg} != count_reg) begin
					rdPend_next = 1'b1;
					idx_next    = idx_reg + 6'h01;
				end else if (!rdPend_reg) begin
					cpuReq_next = 1'b1;
					state_next  = S_CPU;
				end
			end
			S_CPU: begin
				if (cpuDone) begin
					cpuReq_next     = 1'b0;
					respStatus_next = cpuError ? ST_CPU_ERR : ST_OK;
					respValid_next  = 1'b1;
					state_next      = S_RESP;
				end
			end
			S_RESP: begin
				state_next = S_IDLE;
			end
			default: state_next = S_IDLE;
		endcase
		reqReady_next = (state_next == S_IDLE);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg      <= S_IDLE;
			code_reg       <= 8'h00;
			station_reg    <= 8'h00;
			count_reg      <= 9'h000;
			bank_reg       <= BANK_DEV;
			idx_reg        <= IDX_RESET;
			rdPend_reg     <= 1'b0;
			devCnt_reg     <= IDX_RESET;
			devWord_reg    <= 1'b0;
			extCnt_reg     <= IDX_RESET;
			cpuReq_reg     <= 1'b0;
			entryReady_reg <= 1'b0;
			respValid_reg  <= 1'b0;
			respStatus_reg <= ST_OK;
			reqReady_reg   <= 1'b0;
		end else begin
			state_reg      <= state_next;
			code_reg       <= code_next;
			station_reg    <= station_next;
			count_reg      <= count_next;
			bank_reg       <= bank_next;
			idx_reg        <= idx_next;
			rdPend_reg     <= rdPend_next;
			devCnt_reg     <= devCnt_next;
			devWord_reg    <= devWord_next;
			extCnt_reg     <= extCnt_next;
			cpuReq_reg     <= cpuReq_next;
			entryReady_reg <= entryReady_next;
			respValid_reg  <= respValid_next;
			respStatus_reg <= respStatus_next;
			reqReady_reg   <= reqReady_next;
		end
	end

	assign reqReady      = reqReady_reg;
	assign entryReady    = entryReady_reg;
	assign cpuReq        = cpuReq_reg;
	assign cpuCode       = code_reg;
	assign cpuStation    = station_reg;
	assign cpuCount      = count_reg;
	assign cpuEntryValid = rdPend_reg;
	assign respValid     = respValid_reg;
	assign respStatus    = respStatus_reg;

	// Checks
	sequence s_errResp(logic [2:0] st);
		respValid && respStatus == st && !cpuReq;
	endsequence

	property p_bad_code;
		@(posedge clk) disable iff (!resetn)
		accept && !known |=> s_errResp(ST_BAD_CODE);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("unknown code not refused");

	property p_bad_count;
		@(posedge clk) disable iff (!resetn)
		accept && known && kind != KIND_MONITOR && reqCount > limit |=> s_errResp(ST_BAD_COUNT);
	endproperty
	a_bad_count: assert property (p_bad_count) else $error("excess count not refused");

	property p_write_off;
		@(posedge clk) disable iff (!resetn)
		accept && known && isWrite && reqCount <= limit && reqCount != LIM_0 &&
		cpuRunning && !permit_reg |=> s_errResp(ST_WRITE_OFF);
	endproperty
	a_write_off: assert property (p_write_off) else $error("run write not refused");

	property p_write_on;
		@(posedge clk) disable iff (!resetn)
		accept && known && isWrite && reqCount <= limit && reqCount != LIM_0 &&
		permit_reg |=> cpuReq && !respValid;
	endproperty
	a_write_on: assert property (p_write_on) else $error("permitted write refused");

	property p_word_group_limit;
		@(posedge clk) disable iff (!resetn)
		accept && reqCode == CMD_WORD_WRITE && reqWordBits && reqCount == 9'h029
		|=> respStatus == ST_BAD_COUNT;
	endproperty
	a_word_group_limit: assert property (p_word_group_limit) else $error("41 groups taken");

	property p_cpu_hold;
		@(posedge clk) disable iff (!resetn)
		cpuReq && !cpuDone |=> cpuReq && !respValid;
	endproperty
	a_cpu_hold: assert property (p_cpu_hold) else $error("cpu request dropped early");

	sequence s_done;
		cpuReq && cpuDone;
	endsequence

	property p_cpu_result;
		@(posedge clk) disable iff (!resetn)
		s_done |=> respValid && !cpuReq && respStatus == ($past(cpuError) ? ST_CPU_ERR : ST_OK)
		##1 !respValid;
	endproperty
	a_cpu_result: assert property (p_cpu_result) else $error("cpu result not returned");

	property p_mon_unreg;
		@(posedge clk) disable iff (!resetn)
		accept && reqCode == CMD_EXT_MON && extCnt_reg == IDX_RESET
		|=> s_errResp(ST_NOT_REG);
	endproperty
	a_mon_unreg: assert property (p_mon_unreg) else $error("monitor without list");

	property p_replay_count;
		@(posedge clk) disable iff (!resetn)
		state_reg == S_REPLAY && state_next == S_CPU |-> {3'h0, idx_reg} == count_reg;
	endproperty
	a_replay_count: assert property (p_replay_count) else $error("replay length wrong");

endmodule // plc_device_access_command_decoder

// ==== plc_access_pkg.sv ====
package plc_access_pkg;

	// Command codes
	localparam logic [7:0] CMD_BIT_READ      = 8'h00;
	localparam logic [7:0] CMD_WORD_READ     = 8'h01;
	localparam logic [7:0] CMD_BIT_WRITE     = 8'h02;
	localparam logic [7:0] CMD_WORD_WRITE    = 8'h03;
	localparam logic [7:0] CMD_BIT_TEST      = 8'h04;
	localparam logic [7:0] CMD_WORD_TEST     = 8'h05;
	localparam logic [7:0] CMD_BIT_MON_REG   = 8'h06;
	localparam logic [7:0] CMD_WORD_MON_REG  = 8'h07;
	localparam logic [7:0] CMD_BIT_MON       = 8'h08;
	localparam logic [7:0] CMD_WORD_MON      = 8'h09;
	localparam logic [7:0] CMD_BUF_READ      = 8'h0E;
	localparam logic [7:0] CMD_BUF_WRITE     = 8'h0F;
	localparam logic [7:0] CMD_EXT_READ      = 8'h17;
	localparam logic [7:0] CMD_EXT_WRITE     = 8'h18;
	localparam logic [7:0] CMD_EXT_TEST      = 8'h19;
	localparam logic [7:0] CMD_EXT_MON_REG   = 8'h1A;
	localparam logic [7:0] CMD_EXT_MON       = 8'h1B;
	localparam logic [7:0] CMD_EXT_DIR_READ  = 8'h3B;
	localparam logic [7:0] CMD_EXT_DIR_WRITE = 8'h3C;

	// Point limits per request
	localparam logic [8:0] LIM_256 = 9'h100;
	localparam logic [8:0] LIM_128 = 9'h080;
	localparam logic [8:0] LIM_80  = 9'h050;
	localparam logic [8:0] LIM_40  = 9'h028;
	localparam logic [8:0] LIM_20  = 9'h014;
	localparam logic [8:0] LIM_0   = 9'h000;

	// Response status
	localparam logic [2:0] ST_OK        = 3'h0;
	localparam logic [2:0] ST_BAD_CODE  = 3'h1;
	localparam logic [2:0] ST_BAD_COUNT = 3'h2;
	localparam logic [2:0] ST_WRITE_OFF = 3'h3;
	localparam logic [2:0] ST_NOT_REG   = 3'h4;
	localparam logic [2:0] ST_CPU_ERR   = 3'h5;

	// Monitor store
	localparam int         MON_AW      = 7;
	localparam int         ENTRY_W     = 16;
	localparam logic       BANK_DEV    = 1'b0;
	localparam logic       BANK_EXT    = 1'b1;
	localparam logic [5:0] IDX_RESET   = 6'h00;

	typedef enum logic [1:0] {
		KIND_PLAIN,
		KIND_REGISTER,
		KIND_MONITOR
	} cmd_kind_t;

endpackage

// ==== cmd_limit_table.sv ====
`timescale 1ns/1ps
module cmd_limit_table (
	input  wire logic [7:0]                  code,
	input  wire logic                        wordBits,
	output logic                             known,
	output logic                             isWrite,
	output logic [8:0]                       limit,
	output plc_access_pkg::cmd_kind_t        kind,
	output logic                             bank
);
	import plc_access_pkg::*;

	always_comb begin
		known   = 1'b1;
		isWrite = 1'b0;
		limit   = LIM_256;
		kind    = KIND_PLAIN;
		bank    = BANK_DEV;
		case (code)
			CMD_BIT_READ: limit = LIM_256;
			CMD_WORD_READ: limit = wordBits ? LIM_128 : LIM_256;
			CMD_BIT_WRITE: begin
				isWrite = 1'b1;
				limit   = LIM_256;
			end
			CMD_WORD_WRITE: begin
				isWrite = 1'b1;
				limit   = wordBits ? LIM_40 : LIM_256;
			end
			CMD_BIT_TEST: begin
				isWrite = 1'b1;
				limit   = LIM_80;
			end
			CMD_WORD_TEST: begin
				isWrite = 1'b1;
				limit   = LIM_40;
			end
			CMD_BIT_MON_REG: begin
				kind  = KIND_REGISTER;
				limit = LIM_40;
			end
			CMD_WORD_MON_REG: begin
				kind  = KIND_REGISTER;
				limit = LIM_20;
			end
			CMD_BIT_MON, CMD_WORD_MON: begin
				kind  = KIND_MONITOR;
				limit = LIM_0;
			end
			CMD_EXT_READ, CMD_EXT_DIR_READ: limit = LIM_256;
			CMD_EXT_WRITE, CMD_EXT_DIR_WRITE: begin
				isWrite = 1'b1;
				limit   = LIM_256;
			end
			CMD_EXT_TEST: begin
				isWrite = 1'b1;
				limit   = LIM_40;
			end
			CMD_EXT_MON_REG: begin
				kind  = KIND_REGISTER;
				limit = LIM_20;
				bank  = BANK_EXT;
			end
			CMD_EXT_MON: begin
				kind  = KIND_MONITOR;
				limit = LIM_0;
				bank  = BANK_EXT;
			end
			CMD_BUF_READ: limit = LIM_256;
			CMD_BUF_WRITE: begin
				isWrite = 1'b1;
				limit   = LIM_256;
			end
			default: known = 1'b0;
		endcase
	end

endmodule // cmd_limit_table

// ==== monitor_store.sv ====
`timescale 1ns/1ps
module monitor_store (
	input  wire logic                                 clk,
	input  wire logic                                 wrEn,
	input  wire logic [plc_access_pkg::MON_AW-1:0]    wrAddr,
	input  wire logic [plc_access_pkg::ENTRY_W-1:0]   wrData,
	input  wire logic [plc_access_pkg::MON_AW-1:0]    rdAddr,
	output logic      [plc_access_pkg::ENTRY_W-1:0]   rdData
);
	import plc_access_pkg::*;

	logic [ENTRY_W-1:0] mem [0:(1<<MON_AW)-1];

	// Registered read port, no reset on storage
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end

endmodule // monitor_store

// ==== cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       cpuReq,
	input  wire logic [7:0] delay,
	input  wire logic       errOn,
	output logic            cpuDone,
	output logic            cpuError
);
	int   waitCnt;
	logic busy;

	initial begin
		cpuDone = 1'b0;
		cpuError = 1'b0;
		busy = 1'b0;
		waitCnt = 0;
	end

	// Finishes a request at end of scan; error line toggles outside the done cycle
	always @(negedge clk) begin
		cpuDone <= 1'b0;
		cpuError <= ~cpuError;
		if (!resetn) begin
			busy <= 1'b0;
			waitCnt <= 0;
		end else if (busy && !cpuReq) begin
			busy <= 1'b0;
		end else if (cpuReq && !busy) begin
			if (waitCnt >= int'(delay)) begin
				cpuDone <= 1'b1;
				cpuError <= errOn;
				busy <= 1'b1;
				waitCnt <= 0;
			end else begin
				waitCnt <= waitCnt + 1;
			end
		end
	end
endmodule // cpu_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import plc_access_pkg::*;
	logic        clk, resetn, reqValid, reqReady, reqWordBits, entryValid, entryReady;
	logic        runWritePermitSwitch, cpuRunning, cpuReq, cpuEntryValid, cpuDone;
	logic        cpuError, respValid, errOn, reqSeen, respSeen;
	logic [7:0]  reqCode, reqStation, cpuCode, cpuStation, cpuDelay, seenCode, seenStation;
	logic [8:0]  reqCount, cpuCount, seenCount;
	logic [15:0] entryAddr, cpuEntryAddr;
	logic [2:0]  respStatus, seenStatus;
	logic [15:0] replay[$];
	logic [15:0] lists[3][$];
	bit          regd[3];
	logic [31:0] seed;
	int          err_count, comparisons, reqs;

	plc_device_access_command_decoder i_dut (.clk(clk), .resetn(resetn),
		.reqValid(reqValid), .reqReady(reqReady), .reqCode(reqCode),
		.reqStation(reqStation), .reqCount(reqCount), .reqWordBits(reqWordBits),
		.entryValid(entryValid), .entryReady(entryReady), .entryAddr(entryAddr),
		.runWritePermitSwitch(runWritePermitSwitch), .cpuRunning(cpuRunning),
		.cpuReq(cpuReq), .cpuCode(cpuCode), .cpuStation(cpuStation), .cpuCount(cpuCount),
		.cpuEntryValid(cpuEntryValid), .cpuEntryAddr(cpuEntryAddr), .cpuDone(cpuDone),
		.cpuError(cpuError), .respValid(respValid), .respStatus(respStatus));

	cpu_model i_cpu (.clk(clk), .resetn(resetn), .cpuReq(cpuReq), .delay(cpuDelay),
		.errOn(errOn), .cpuDone(cpuDone), .cpuError(cpuError));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Samples the settled outputs just after each rising edge
	always @(posedge clk) begin
		#1;
		if (cpuEntryValid === 1'b1) replay.push_back(cpuEntryAddr);
		if (cpuReq === 1'b1 && !reqSeen) begin
			reqSeen = 1'b1;
			reqs++;
			seenCode = cpuCode;
			seenStation = cpuStation;
			seenCount = cpuCount;
		end
		if (cpuReq !== 1'b1) reqSeen = 1'b0;
		if (respValid === 1'b1) begin
			respSeen = 1'b1;
			seenStatus = respStatus;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int limit_of(input logic [7:0] c, input logic w);
		case (c)
			8'h00, 8'h02: return LIM_256;
			8'h01: return w ? LIM_128 : LIM_256;
			8'h03: return w ? LIM_40 : LIM_256;
			8'h04: return LIM_80;
			8'h05, 8'h19: return LIM_40;
			8'h06: return LIM_40;
			8'h07, 8'h1A: return LIM_20;
			8'h08, 8'h09, 8'h1B: return 0;
			8'h0E, 8'h0F, 8'h17, 8'h18, 8'h3B, 8'h3C: return LIM_256;
			default: return -1;
		endcase
	endfunction

	function automatic int bank_of(input logic [7:0] c);
		case (c)
			8'h06, 8'h08: return 0;
			8'h07, 8'h09: return 1;
			8'h1A, 8'h1B: return 2;
			default: return -1;
		endcase
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic do_cmd(input logic [7:0] code, input logic [8:0] count, input logic wb);
		int lim, b, st, t, n;
		logic [15:0] ent[$];
		lim = limit_of(code, wb);
		b = bank_of(code);
		st = ST_OK;
		if (lim < 0) st = ST_BAD_CODE;
		else if (lim > 0 && (count == 0 || count > lim)) st = ST_BAD_COUNT;
		else if (code inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h0F, 8'h18, 8'h19, 8'h3C}
			&& cpuRunning && !runWritePermitSwitch) st = ST_WRITE_OFF;
		else if (lim == 0 && !regd[b]) st = ST_NOT_REG;
		else if (errOn) st = ST_CPU_ERR;
		if (st == ST_OK && lim > 0 && b >= 0) begin
			for (n = 0; n < count; n++) ent.push_back(rnd());
		end
		n = reqs;
		replay = {};
		respSeen = 1'b0;
		for (t = 0; t < 100 && reqReady !== 1'b1; t++) @(negedge clk);
		reqValid = 1'b1;
		reqCode = code;
		reqCount = count;
		reqWordBits = wb;
		reqStation = 8'hFF;
		@(negedge clk);
		reqValid = 1'b0;
		reqCode = ~code;
		reqCount = ~count;
		reqStation = 8'h00;
		foreach (ent[i]) begin
			for (t = 0; t < 50 && entryReady !== 1'b1; t++) @(negedge clk);
			entryValid = 1'b1;
			entryAddr = ent[i];
			@(negedge clk);
		end
		entryValid = 1'b0;
		entryAddr = ~entryAddr;
		for (t = 0; t < 600 && !respSeen; t++) @(negedge clk);
		check(respSeen, 1'b1);
		check(seenStatus, st);
		check(reqs - n, (st == ST_OK || st == ST_CPU_ERR) ? 1 : 0);
		if (reqs != n) begin
			check(seenCode, code);
			check(seenStation, 8'hFF);
			check(seenCount, (lim == 0) ? lists[b].size() : count);
		end
		if (st == ST_OK && lim > 0 && b >= 0) begin
			lists[b] = ent;
			regd[b] = 1'b1;
			if (b < 2) regd[1 - b] = 1'b0;
		end
		if (st == ST_OK && lim == 0) begin
			check(replay.size(), lists[b].size());
			foreach (lists[b][i]) if (i < replay.size()) check(replay[i], lists[b][i]);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		summarize();
	end

	initial begin
		logic [31:0] r;
		logic [7:0] rc[13];
		logic [7:0] wc[8];
		int lim;
		rc = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h17, 8'h18, 8'h19, 8'h3B,
			8'h3C, 8'h0A, 8'h16};
		wc = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h0F, 8'h18, 8'h19, 8'h3C};
		seed = 32'h11A6F;
		{resetn, reqValid, reqWordBits, entryValid, errOn, reqSeen, respSeen} = 7'h00;
		{reqCode, reqStation, reqCount, entryAddr, cpuDelay} = 49'h0;
		runWritePermitSwitch = 1'b0;
		cpuRunning = 1'b0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		do_cmd(8'h08, 9'h001, 1'b0);
		do_cmd(8'h09, 9'h001, 1'b0);
		do_cmd(8'h1B, 9'h001, 1'b0);
		do_cmd(8'h06, 9'h029, 1'b0);
		do_cmd(8'h06, 9'h003, 1'b0);
		cpuDelay = 8'h14;
		do_cmd(8'h08, 9'h001, 1'b0);
		do_cmd(8'h06, 9'h028, 1'b0);
		do_cmd(8'h08, 9'h001, 1'b0);
		cpuDelay = 8'h00;
		do_cmd(8'h07, 9'h014, 1'b1);
		do_cmd(8'h09, 9'h001, 1'b1);
		do_cmd(8'h08, 9'h001, 1'b0);
		do_cmd(8'h1A, 9'h015, 1'b0);
		do_cmd(8'h1A, 9'h014, 1'b0);
		do_cmd(8'h1B, 9'h001, 1'b0);
		do_cmd(8'h0E, 9'h080, 1'b0);
		do_cmd(8'h0F, 9'h101, 1'b0);
		do_cmd(8'h03, 9'h029, 1'b1);
		do_cmd(8'h0B, 9'h001, 1'b0);
		errOn = 1'b1;
		do_cmd(8'h00, 9'h100, 1'b0);
		errOn = 1'b0;
		$display("test monitor and limits done");
		for (int m = 0; m < 3; m++) begin
			cpuRunning = (m != 2);
			runWritePermitSwitch = (m == 1);
			repeat (4) @(negedge clk);
			foreach (wc[i]) do_cmd(wc[i], 9'h001, 1'b0);
		end
		$display("test write gate done");
		for (int k = 0; k < 40; k++) begin
			r = rnd();
			cpuRunning = r[5];
			errOn = (r[3:0] == 4'h0);
			cpuDelay = r[7] ? 8'h00 : 8'(r[15:10]);
			lim = limit_of(rc[r[31:16] % 13], r[4]);
			case (r[9:8])
				2'h0: do_cmd(rc[r[31:16] % 13], (lim > 0) ? 9'(lim + 1) : 9'(r[24:16]), r[4]);
				2'h1: do_cmd(rc[r[31:16] % 13], (lim > 0) ? 9'(lim) : 9'h001, r[4]);
				2'h2: do_cmd(rc[r[31:16] % 13], 9'h001, r[4]);
				default: do_cmd(rc[r[31:16] % 13], 9'h000, r[4]);
			endcase
		end
		$display("test random commands done");
		summarize();
	end
endmodule // tb
